//--- pieb_bank.sv
/*
  pieb_bank: peripheral interrupt enable and request register bank.
  holds global control, two enable and two request registers and
  forms the request to the core.
  assumes: peripheral events are one-cycle pulses on core_clk_in;
  software master follows the plain strobe port protocol.
*/
// What this block does
// - second enable bit 7 enables oscillator-failure interrupt
// - second enable bits 6 and 5 enable comparator b and a
// - second enable bit 3 enables bus-collision interrupt
// - second enable bit 2 enables USB engine interrupt
// - second enable bit 1 enables clock tuning interrupt
// - unimplemented bits read zero: bank two bits 4,0, bank one bit 2
// - peripheral requests need the group enable as well as own enable
// - flags set on source events regardless of the interrupt enables, but only while clk_en_in is high
// - first request bit 7 timer one gate, bit 6 conversion done
// - first request bit 5 serial receive, bit 4 serial transmit
// - first request bit 3 synchronous serial port
// - first request bit 1 timer two match, bit 0 timer one overflow
// - second request bit 7 oscillator failure
// - second request bits 6 and 5 comparator b and a
// - second request bit 3 bus collision, 2 USB, 1 clock tuning
// - flag one means pending, zero means none pending
// - all implemented bits reset to zero and are read/write
// - no interrupt reaches core while global enable is zero
`timescale 1ns/1ps
module pieb_bank
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [pieb_pkg::PIEB_ADDR_W-1:0] reg_addr_in,
  input wire logic [pieb_pkg::PIEB_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [pieb_pkg::PIEB_DATA_W-1:0] reg_rdata_out,
  // first bank events
  input wire logic timer_one_gate_evt_in,
  input wire logic conversion_done_evt_in,
  input wire logic serial_rx_evt_in,
  input wire logic serial_tx_evt_in,
  input wire logic sync_serial_evt_in,
  input wire logic timer_two_match_evt_in,
  input wire logic timer_one_overflow_evt_in,
  // second bank events
  input wire logic osc_fail_evt_in,
  input wire logic comparator_b_evt_in,
  input wire logic comparator_a_evt_in,
  input wire logic bus_collision_evt_in,
  input wire logic usb_engine_evt_in,
  input wire logic clock_tuning_evt_in,
  // core side
  output logic periph_irq_out,
  output logic core_irq_out,
  output logic global_irq_enable_out
);

  import pieb_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  logic wr_gctl;
  logic wr_en1;
  logic wr_en2;
  logic wr_req1;
  logic wr_req2;

  assign wr_gctl = reg_wr_in && hit(reg_addr_in, PIEB_OFF_GCTL);
  assign wr_en1 = reg_wr_in && hit(reg_addr_in, PIEB_OFF_EN1);
  assign wr_en2 = reg_wr_in && hit(reg_addr_in, PIEB_OFF_EN2);
  assign wr_req1 = reg_wr_in && hit(reg_addr_in, PIEB_OFF_REQ1);
  assign wr_req2 = reg_wr_in && hit(reg_addr_in, PIEB_OFF_REQ2);

  ////////////////////////////////////////////////////////////////////
  // control and enable registers

  logic [7:0] gctl_r;
  logic [7:0] en1_r;
  logic [7:0] en2_r;

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      gctl_r <= PIEB_RST_VAL;
    end
    else if (clk_en_in && wr_gctl)
    begin
      gctl_r <= reg_wdata_in & PIEB_MASK_GCTL;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      en1_r <= PIEB_RST_VAL;
    end
    else if (clk_en_in && wr_en1)
    begin
      en1_r <= reg_wdata_in & PIEB_MASK_B1;
    end
  end

  // unused positions masked so they always read zero
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      en2_r <= PIEB_RST_VAL;
    end
    else if (clk_en_in && wr_en2)
    begin
      en2_r <= reg_wdata_in & PIEB_MASK_B2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // request flags

  logic [7:0] evt1;
  logic [7:0] evt2;
  logic [7:0] req1_r;
  logic [7:0] req2_r;

  always_comb
  begin
    evt1 = 8'h00;
    evt1[PIEB_B1_TMR1_GATE] = timer_one_gate_evt_in;
    evt1[PIEB_B1_CONV_DONE] = conversion_done_evt_in;
    evt1[PIEB_B1_SER_RX] = serial_rx_evt_in;
    evt1[PIEB_B1_SER_TX] = serial_tx_evt_in;
    evt1[PIEB_B1_SYNC_SER] = sync_serial_evt_in;
    evt1[PIEB_B1_TMR2_MATCH] = timer_two_match_evt_in;
    evt1[PIEB_B1_TMR1_OVF] = timer_one_overflow_evt_in;
  end

  always_comb
  begin
    evt2 = 8'h00;
    evt2[PIEB_B2_OSC_FAIL] = osc_fail_evt_in;
    evt2[PIEB_B2_CMP_B] = comparator_b_evt_in;
    evt2[PIEB_B2_CMP_A] = comparator_a_evt_in;
    evt2[PIEB_B2_BUS_COLL] = bus_collision_evt_in;
    evt2[PIEB_B2_USB] = usb_engine_evt_in;
    evt2[PIEB_B2_CLK_TUNE] = clock_tuning_evt_in;
  end

  pieb_flag_reg u_req1
  (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_req1),
    .wr_data_in(reg_wdata_in),
    .event_in(evt1),
    .mask_in(PIEB_MASK_B1),
    .flags_out(req1_r)
  );

  pieb_flag_reg u_req2
  (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_req2),
    .wr_data_in(reg_wdata_in),
    .event_in(evt2),
    .mask_in(PIEB_MASK_B2),
    .flags_out(req2_r)
  );

  ////////////////////////////////////////////////////////////////////
  // request to the core

  logic any_periph;

  // combinational so a flag reaches the core in the cycle it is seen
  assign any_periph = |((req1_r & en1_r) | (req2_r & en2_r));
  assign periph_irq_out = any_periph && gctl_r[PIEB_GCTL_GROUP_BIT];
  assign core_irq_out = periph_irq_out && gctl_r[PIEB_GCTL_GLOBAL_BIT];
  assign global_irq_enable_out = gctl_r[PIEB_GCTL_GLOBAL_BIT];

  ////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rd_mux;

  always_comb
  begin
    case (reg_addr_in)
      PIEB_OFF_GCTL: rd_mux = gctl_r;
      PIEB_OFF_EN1: rd_mux = en1_r;
      PIEB_OFF_EN2: rd_mux = en2_r;
      PIEB_OFF_REQ1: rd_mux = req1_r;
      PIEB_OFF_REQ2: rd_mux = req2_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // data stands in the cycle after a strobe taken with clk_en_in high, and holds while clk_en_in is low
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (clk_en_in)
    begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

endmodule // pieb_bank

//--- pieb_pkg.sv
/*
  pieb_pkg: register offsets, field positions, reset values and masks
  for the peripheral interrupt enable and flag bank.
  assumes: byte-wide registers reached over a plain strobe port.
*/
package pieb_pkg;

  localparam int PIEB_ADDR_W = 3;
  localparam int PIEB_DATA_W = 8;

  // register offsets
  localparam logic [2:0] PIEB_OFF_GCTL = 3'h0;
  localparam logic [2:0] PIEB_OFF_EN1 = 3'h1;
  localparam logic [2:0] PIEB_OFF_EN2 = 3'h2;
  localparam logic [2:0] PIEB_OFF_REQ1 = 3'h3;
  localparam logic [2:0] PIEB_OFF_REQ2 = 3'h4;

  // global interrupt control fields
  localparam int PIEB_GCTL_GLOBAL_BIT = 7;
  localparam int PIEB_GCTL_GROUP_BIT = 6;

  // first bank fields
  localparam int PIEB_B1_TMR1_GATE = 7;
  localparam int PIEB_B1_CONV_DONE = 6;
  localparam int PIEB_B1_SER_RX = 5;
  localparam int PIEB_B1_SER_TX = 4;
  localparam int PIEB_B1_SYNC_SER = 3;
  localparam int PIEB_B1_TMR2_MATCH = 1;
  localparam int PIEB_B1_TMR1_OVF = 0;

  // second bank fields
  localparam int PIEB_B2_OSC_FAIL = 7;
  localparam int PIEB_B2_CMP_B = 6;
  localparam int PIEB_B2_CMP_A = 5;
  localparam int PIEB_B2_BUS_COLL = 3;
  localparam int PIEB_B2_USB = 2;
  localparam int PIEB_B2_CLK_TUNE = 1;

  // implemented-bit masks
  localparam logic [7:0] PIEB_MASK_GCTL = 8'hc0;
  localparam logic [7:0] PIEB_MASK_B1 = 8'hfb;
  localparam logic [7:0] PIEB_MASK_B2 = 8'hee;

  // reset values
  localparam logic [7:0] PIEB_RST_VAL = 8'h00;

endpackage

//--- pieb_flag_reg.sv
/*
  pieb_flag_reg: one byte of sticky request flags.
  assumes: events are single-clock pulses synchronous to core_clk_in.
*/
`timescale 1ns/1ps
module pieb_flag_reg
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // software write and hardware events
  input wire logic wr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] event_in,
  input wire logic [7:0] mask_in,
  // flags
  output logic [7:0] flags_out
);

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      flags_out <= 8'h00;
    end
    else if (clk_en_in)
    begin
      // set beats a write of zero in the same cycle
      if (wr_in)
      begin
        flags_out <= (wr_data_in | event_in) & mask_in;
      end
      else
      begin
        flags_out <= (flags_out | event_in) & mask_in;
      end
    end
  end

endmodule // pieb_flag_reg

//--- pieb_periph_model.sv
/*
  pieb_periph_model: stand-in for the on-chip peripherals.
  assumes: the bench sets fire_in; each bit becomes one event pulse.
*/
`timescale 1ns/1ps
module pieb_periph_model
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // bench command and event lines
  input wire logic [12:0] fire_in,
  output logic [12:0] evt_out
);
  // registered, so events never move on the sampling edge itself
  always_ff @(posedge core_clk_in)
    evt_out <= srst_in ? 13'h0000 : fire_in;
endmodule // pieb_periph_model

//--- pieb_bank_monitor.sv
/*
  pieb_bank_monitor: port assertions for the interrupt bank.
  assumes: one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module pieb_bank_monitor
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [pieb_pkg::PIEB_ADDR_W-1:0] reg_addr_in,
  input wire logic [pieb_pkg::PIEB_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [pieb_pkg::PIEB_DATA_W-1:0] reg_rdata_out,
  // core side
  input wire logic periph_irq_out,
  input wire logic core_irq_out,
  input wire logic global_irq_enable_out
);
  import pieb_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic rd;
  logic wr;
  assign rd = reg_rd_in && clk_en_in;
  assign wr = reg_wr_in && clk_en_in;
  AST_RST_CLEAN: assert property ($fell(srst_in) |-> reg_rdata_out == 8'h00
    && !core_irq_out && !periph_irq_out && !global_irq_enable_out) else $error("not clear");
  AST_RD_IDLE: assert property (clk_en_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read");
  AST_RD_HOLES: assert property (rd |=> (reg_rdata_out & ~(reg_addr_in == 3'h0 ? 8'hc0 :
    reg_addr_in == 3'h1 || reg_addr_in == 3'h3 ? 8'hfb : reg_addr_in == 3'h2 ||
    reg_addr_in == 3'h4 ? 8'hee : 8'h00)) == 8'h00) else $error("hole reads one");
  AST_CORE_GATE: assert property (core_irq_out |-> periph_irq_out && global_irq_enable_out)
    else $error("core request ungated");
  AST_GIE_WR: assert property (wr && reg_addr_in == 3'h0 |=>
    global_irq_enable_out == $past(reg_wdata_in[7])) else $error("global enable lost");
  AST_GROUP_OFF: assert property (wr && reg_addr_in == 3'h0 && !reg_wdata_in[6] |=>
    !periph_irq_out) else $error("request without group enable");
  AST_IRQ_HOLD: assert property (periph_irq_out && !reg_wr_in |=> periph_irq_out)
    else $error("request dropped");
  AST_EN_BACK: assert property (wr && reg_addr_in == 3'h1 ##1 !reg_wr_in ##1 rd &&
    reg_addr_in == 3'h1 |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'hfb))
    else $error("enable readback");
  cover property (core_irq_out);
  cover property ($rose(periph_irq_out));
  cover property (rd && reg_addr_in == 3'h4);
endmodule // pieb_bank_monitor
bind pieb_bank pieb_bank_monitor mon (.core_clk_in, .srst_in, .clk_en_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .periph_irq_out, .core_irq_out,
  .global_irq_enable_out);

//--- pieb_bank_tb.sv
/*
  pieb_bank_tb: self-checking bench for the interrupt bank.
  assumes: design files and peripheral model compiled first.
*/
`timescale 1ns/1ps
module pieb_bank_tb;
  import pieb_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic w = 1'b0;
  logic r = 1'b0;
  logic [2:0] a = 3'h0;
  logic [7:0] d = 8'h00;
  logic [12:0] f = 13'h0000;
  logic [12:0] ev;
  logic [7:0] rdata;
  logic pirq;
  logic cirq;
  logic global_irq_enable;
  logic ce = 1'b1;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  logic [7:0] v;
  logic [2:0] q;
  logic [2:0] e;
  pieb_periph_model pm (.core_clk_in(clk), .srst_in(srst), .fire_in(f), .evt_out(ev));
  pieb_bank uut (.core_clk_in(clk), .srst_in(srst), .clk_en_in(ce), .reg_addr_in(a),
    .reg_wdata_in(d), .reg_wr_in(w), .reg_rd_in(r), .reg_rdata_out(rdata),
    .timer_one_overflow_evt_in(ev[0]), .timer_two_match_evt_in(ev[1]),
    .sync_serial_evt_in(ev[2]), .serial_tx_evt_in(ev[3]), .serial_rx_evt_in(ev[4]),
    .conversion_done_evt_in(ev[5]), .timer_one_gate_evt_in(ev[6]),
    .clock_tuning_evt_in(ev[7]), .usb_engine_evt_in(ev[8]), .bus_collision_evt_in(ev[9]),
    .comparator_a_evt_in(ev[10]), .comparator_b_evt_in(ev[11]), .osc_fail_evt_in(ev[12]),
    .periph_irq_out(pirq), .core_irq_out(cirq), .global_irq_enable_out(global_irq_enable));
  //////////////////////////////////////////
  function automatic logic [7:0] pos(int j);
    int b[13] = '{0, 1, 3, 4, 5, 6, 7, 1, 2, 3, 5, 6, 7};
    return 8'h01 << b[j];
  endfunction
  function automatic logic [7:0] msk(int i);
    return i == 0 ? 8'hc0 : i == 1 || i == 3 ? 8'hfb : i == 2 || i == 4 ? 8'hee : 8'h00;
  endfunction
  task automatic chk(logic [7:0] g, logic [7:0] x);
    n_checks++;
    if (g !== x)
    begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(logic [2:0] ad, logic [7:0] dt);
    @(posedge clk);
    a <= ad;
    d <= dt;
    w <= 1'b1;
    @(posedge clk);
    w <= 1'b0;
  endtask
  task automatic rd(logic [2:0] ad, logic [7:0] x);
    @(posedge clk);
    a <= ad;
    r <= 1'b1;
    @(posedge clk);
    r <= 1'b0;
    #1 chk(rdata, x);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(32'h18615f95));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(i[2:0], 8'h00);
    $display("test reset done");
    for (int i = 0; i < 30; i++)
    begin
      k = i < 6 ? i : $urandom_range(5);
      v = i < 6 ? 8'hff : 8'($urandom);
      wr(k[2:0], v);
      rd(k[2:0], v & msk(k));
    end
    for (int i = 0; i < 5; i++)
      wr(i[2:0], 8'h00);
    $display("test access done");
    for (int j = 0; j < 13; j++)
    begin
      q = j < 7 ? 3'h3 : 3'h4;
      e = j < 7 ? 3'h1 : 3'h2;
      wr(q, 8'h00);
      wr(3'h0, 8'hc0);
      @(posedge clk);
      f <= 13'h0001 << j;
      @(posedge clk);
      f <= 13'h0000;
      @(posedge clk);
      #1 chk({6'h00, pirq, cirq}, 8'h00);
      rd(q, pos(j));
      wr(e, pos(j));
      for (int g = 0; g < 4; g++)
      begin
        wr(3'h0, {g[1:0], 6'h00});
        #1 chk({5'h00, global_irq_enable, pirq, cirq}, {5'h00, g[1], g[0], g[0] & g[1]});
      end
      wr(e, 8'h00);
    end
    $display("test events done");
    wr(3'h3, 8'h00);
    @(posedge clk);
    f <= 13'h0001;
    fork
      wr(3'h3, 8'h00);
      @(posedge clk) f <= 13'h0000;
    join
    rd(3'h3, 8'h01);
    wr(3'h3, 8'h00);
    rd(3'h3, 8'h00);
    $display("test collide done");
    // clock enable low: neither a write nor an event may land
    @(posedge clk);
    ce <= 1'b0;
    wr(3'h0, 8'h00);
    f <= 13'h0002;
    @(posedge clk);
    f <= 13'h0000;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    #1 chk({7'h00, global_irq_enable}, 8'h01);
    rd(3'h3, 8'h00);
    $display("test freeze done");
    summarize();
  end
endmodule // pieb_bank_tb
